// File: verilog/msrs_selector.sv
// speed reference selector: sensor channel choice and stepped ramp
// What this block does
// - six sensor envelopes, 45 degree repeat, 7.5 degree offsets, arrive as inputs.
// - each candidate is the sum of three neighbouring sensor levels.
// - at most one composite signal drives the selected node.
// - a new selection happens only at each ramp start.
// - chosen signal rises in the commanded direction.
// - chosen signal is below about half its maximum when selected.
// - selection holds until the next ramp start.
// - ramp spans half the maximum sensor signal, centred in range.
// - six identical channels, each a set-reset latch gating its signal.
// - pair comparator high when signal exceeds its opposite around the ring.
// - each ramp start makes a short clear pulse and a long start pulse.
// - clear pulse forces all six latches off.
// - after clear ends, channels with active enables turn on.
// - forward command: a turned-on channel trips its neighbour, leaving one.
// - ramp rate follows the input pulse frequency, 12 per minute to 2 per hour.
// - each input pulse raises the ramp one step, 16 steps then wrap.
// - counter is four stages toggling on falling input, weights 1,2,4,8.
// - each stage weighs twice the previous one in the ramp output.
// - ramp equals weighted count plus a fixed centring offset.
// - positive error drives faster, negative error slows the motor.
// - long start pulse issued when a new ramp begins, triggering selection.
// - behind flag high while ramp exceeds selected signal, else reverse.
`timescale 1ns/1ns
`default_nettype none
module msrs_selector (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire msrs_pkg::msrs_sensors_s sensors,
  input  wire logic                   forward_command,
  input  wire logic                   forward_command_aux,
  input  wire logic                   countPulse,
  input  wire logic                   rampRestart,
  output msrs_pkg::msrs_sum_t         rampLevel,
  output msrs_pkg::msrs_sel_s         selected,
  output logic                        motor_behind_flag,
  output logic                        driveForward,
  output logic                        driveReverse,
  output logic                        startPulse,
  output logic                        clearPulse
);
  localparam int N = msrs_pkg::NUM_CHAN;

  // composite sums of three neighbours
  msrs_pkg::msrs_sum_t comp [N];
  logic [N-1:0]        pairHigh;
  logic [N-1:0]        rising;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_comp
      assign comp[g] = msrs_pkg::msrs_sum_t'(sensors.level[g])
                     + msrs_pkg::msrs_sum_t'(sensors.level[(g+1)%N])
                     + msrs_pkg::msrs_sum_t'(sensors.level[(g+2)%N]);
      assign pairHigh[g] = comp[g] > comp[(g+3)%N];
    end
  endgenerate

  // candidate rises in commanded direction and is below half maximum
  generate
    for (g = 0; g < N; g++)
    begin : g_cand
      assign rising[g] = (forward_command ? pairHigh[(g+N-1)%N] & ~pairHigh[g]
                                          : pairHigh[(g+1)%N] & ~pairHigh[g])
                       & (comp[g] <= msrs_pkg::SEL_LIMIT);
    end
  endgenerate

  // counter input falling-edge detection
  logic       pulsePrev_q;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic       restartPrev_q;
  wire        pulseFall = pulsePrev_q & ~countPulse;
  wire        restartRise = rampRestart & ~restartPrev_q;
  // ripple of four stages: each toggles when the previous falls
  logic [3:0] toggle;
  assign toggle[0] = pulseFall;
  assign toggle[1] = toggle[0] & count_q[0];
  assign toggle[2] = toggle[1] & count_q[1];
  assign toggle[3] = toggle[2] & count_q[2];
  assign count_d   = restartRise ? msrs_pkg::RESET_COUNT : (count_q ^ toggle);
  wire  wrap       = pulseFall & (count_q == 4'hf);
  wire  rampStart  = wrap | restartRise;

  // weights 1,2,4,8 scaled by step, plus centring offset
  wire msrs_pkg::msrs_sum_t rampD = msrs_pkg::RAMP_OFFSET
                                  + msrs_pkg::msrs_sum_t'(count_d)
                                  * msrs_pkg::STEP_SIZE;

  // selection sequencer
  msrs_pkg::msrs_state_e state_q;
  msrs_pkg::msrs_state_e state_d;
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      msrs_pkg::IDLE:     if (rampStart) state_d = msrs_pkg::CLEARING;
      msrs_pkg::CLEARING: state_d = msrs_pkg::ENABLING;
      msrs_pkg::ENABLING: state_d = msrs_pkg::HOLDING;
      msrs_pkg::HOLDING:  if (rampStart) state_d = msrs_pkg::CLEARING;
    endcase
  end
  wire clrNow = state_q == msrs_pkg::CLEARING;
  wire enNow  = state_q == msrs_pkg::ENABLING;

  // channels: each trips its predecessor candidate in forward sense
  logic [N-1:0] latchOn;
  logic [N-1:0] tripOne;
  logic [N-1:0] tripTwo;
  logic [N-1:0] tripIn;
  generate
    for (g = 0; g < N; g++)
    begin : g_chan
      assign tripIn[g] = forward_command_aux ? tripTwo[(g+1)%N] & latchOn[g]
                                             : tripOne[(g+N-1)%N] & latchOn[g];
      msrs_channel u_chan (
        .mclk                  (mclk),
        .reset                 (reset),
        .ce                    (ce),
        .clearPulse            (clrNow),
        .enablePulse           (enNow),
        .channel_enable_in_one (rising[g]),
        .channel_enable_in_two (1'b1),
        .tripIn                (tripIn[g]),
        .channel_trip_out_one  (tripOne[g]),
        .channel_trip_out_two  (tripTwo[g]),
        .latchOn               (latchOn[g])
      );
    end
  endgenerate

  // pick the lowest live channel so at most one drives the node
  logic [2:0] pickIdx;
  logic       pickAny;
  always_comb
  begin
    pickIdx = 3'h0;
    pickAny = 1'b0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (latchOn[i])
      begin
        pickIdx = 3'(i);
        pickAny = 1'b1;
      end
    end
  end
  wire msrs_pkg::msrs_sum_t busLevel = pickAny ? comp[pickIdx] : '0;
  wire behind = rampD > busLevel;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pulsePrev_q   <= 1'b0;
      restartPrev_q <= 1'b0;
      count_q       <= msrs_pkg::RESET_COUNT;
      state_q       <= msrs_pkg::IDLE;
    end
    else if (ce)
    begin
      pulsePrev_q   <= countPulse;
      restartPrev_q <= rampRestart;
      count_q       <= count_d;
      state_q       <= state_d;
    end
  end

  // registered outputs
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rampLevel         <= msrs_pkg::RAMP_OFFSET;
      selected          <= '0;
      motor_behind_flag <= 1'b0;
      driveForward      <= 1'b0;
      driveReverse      <= 1'b0;
      startPulse        <= 1'b0;
      clearPulse        <= 1'b0;
    end
    else if (ce)
    begin
      rampLevel         <= rampD;
      selected          <= '{selValid: pickAny, selIndex: pickIdx, selLevel: busLevel};
      motor_behind_flag <= behind;
      // lag drives commanded direction, lead commands reverse
      driveForward      <= behind ? forward_command : ~forward_command;
      driveReverse      <= behind ? ~forward_command : forward_command;
      startPulse        <= (state_d != msrs_pkg::IDLE) & (state_d != msrs_pkg::HOLDING)
                           | (state_q == msrs_pkg::ENABLING);
      clearPulse        <= state_d == msrs_pkg::CLEARING;
    end
  end

  property p_one_hot;
    @(posedge mclk) disable iff (reset) $onehot0(latchOn) || state_q == msrs_pkg::ENABLING;
  endproperty
  chk_one_driver: assert property (p_one_hot) else $error("more than one channel on");

  chk_clear_all: assert property (@(posedge mclk) disable iff (reset)
    ce && state_q == msrs_pkg::CLEARING |=> latchOn == '0)
    else $error("clear pulse left a channel on");

  chk_hold_sel: assert property (@(posedge mclk) disable iff (reset)
    ce && state_q == msrs_pkg::HOLDING && !rampStart |=> $stable(latchOn))
    else $error("selection changed mid period");

  sequence s_start;
    ce && rampStart;
  endsequence
  sequence s_clear_then_enable;
    state_q == msrs_pkg::CLEARING ##1 state_q == msrs_pkg::ENABLING;
  endsequence
  chk_start_seq: assert property (@(posedge mclk) disable iff (reset || !ce)
    s_start |=> s_clear_then_enable)
    else $error("ramp start did not clear then enable");

  chk_ramp_wrap: assert property (@(posedge mclk) disable iff (reset)
    ce && pulseFall && !restartRise && count_q == 4'hf |=> count_q == 4'h0)
    else $error("counter did not wrap after 16 steps");

  chk_ramp_step: assert property (@(posedge mclk) disable iff (reset)
    ce && pulseFall && !restartRise && count_q != 4'hf |=> count_q == $past(count_q) + 4'h1)
    else $error("counter did not step on falling input");

  chk_ramp_hold: assert property (@(posedge mclk) disable iff (reset)
    ce && !pulseFall && !restartRise |=> $stable(count_q))
    else $error("counter moved without falling input");

  chk_ramp_level: assert property (@(posedge mclk) disable iff (reset)
    ce |=> rampLevel == msrs_pkg::RAMP_OFFSET
           + msrs_pkg::msrs_sum_t'(count_q) * msrs_pkg::STEP_SIZE)
    else $error("ramp level not weighted count plus offset");

  chk_behind_flag: assert property (@(posedge mclk) disable iff (reset)
    ce && rampD > busLevel |=> motor_behind_flag && (driveForward == $past(forward_command)))
    else $error("lag not flagged or wrong drive");
endmodule : msrs_selector
`default_nettype wire

// File: verilog/msrs_pkg.sv
// shared constants and carrier types for the speed reference selector
package msrs_pkg;
  localparam int                SENSOR_BITS  = 10;
  localparam int                SUM_BITS     = 12;
  localparam int                NUM_CHAN     = 6;
  localparam int                RAMP_STAGES  = 4;
  localparam int                RAMP_STEPS   = 16;
  localparam logic [11:0]       STEP_SIZE    = 12'h060;
  localparam logic [11:0]       RAMP_OFFSET  = 12'h300;
  localparam logic [11:0]       SUM_MAX      = 12'hbfd;
  localparam logic [11:0]       SEL_LIMIT    = 12'h5fe;
  localparam real               SECTOR_DEG   = 45.0;
  localparam real               OFFSET_DEG   = 7.5;
  localparam real               CLEAR_NS     = 20.0;
  localparam real               CLK_NS       = 10.0;
  localparam int                CLEAR_CYC    =
    (CLEAR_NS / CLK_NS) < 1.0 ? 1 : int'(CLEAR_NS / CLK_NS);
  localparam logic [3:0]        RESET_COUNT  = 4'h0;

  typedef logic [SENSOR_BITS-1:0] msrs_sensor_t;
  typedef logic [SUM_BITS-1:0]    msrs_sum_t;

  typedef struct packed {
    msrs_sensor_t [NUM_CHAN-1:0] level;
  } msrs_sensors_s;

  typedef struct packed {
    logic       selValid;
    logic [2:0] selIndex;
    msrs_sum_t  selLevel;
  } msrs_sel_s;

  typedef enum logic [1:0] {IDLE, CLEARING, ENABLING, HOLDING} msrs_state_e;
endpackage : msrs_pkg

// File: verilog/msrs_channel.sv
// one selection channel: set-reset latch gating its composite signal
`timescale 1ns/1ns
`default_nettype none
module msrs_channel (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic clearPulse,
  input  wire logic enablePulse,
  input  wire logic channel_enable_in_one,
  input  wire logic channel_enable_in_two,
  input  wire logic tripIn,
  output logic      channel_trip_out_one,
  output logic      channel_trip_out_two,
  output logic      latchOn
);
  logic latch_q;
  logic latch_d;
  wire  setOk = enablePulse & channel_enable_in_one & channel_enable_in_two;
  // clear dominates, then trip from neighbour, then set
  assign latch_d = clearPulse ? 1'b0 : (tripIn ? 1'b0 : (setOk ? 1'b1 : latch_q));
  assign latchOn = latch_q;
  assign channel_trip_out_one = latch_q;
  assign channel_trip_out_two = latch_q;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      latch_q <= 1'b0;
    else if (ce)
      latch_q <= latch_d;
  end
endmodule : msrs_channel
`default_nettype wire

// File: testbench/msrs_motor_model.sv
// motor model: six rectified sensor envelopes following a simulated rotor
`timescale 1ns/1ns
`default_nettype none
module msrs_motor_model (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               stepEn,
  input  wire logic               driveForward,
  input  wire logic               driveReverse,
  output msrs_pkg::msrs_sensors_s sensors
);
  logic [5:0] angle_q;

  // 48 steps per 45 degree repeat, 8 steps apart
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      angle_q <= 6'h00;
    else if (stepEn && driveForward)
      angle_q <= (angle_q == 6'h2f) ? 6'h00 : angle_q + 6'h01;
    else if (stepEn && driveReverse)
      angle_q <= (angle_q == 6'h00) ? 6'h2f : angle_q - 6'h01;

  // triangular envelopes, peak 1008; each sensor trails the one before
  always_comb
    for (int i = 0; i < 6; i++)
    begin : env
      int p;
      p = (angle_q + 48 - 8 * i) % 48;
      sensors.level[i] = (p < 24) ? 10'(p * 42) : 10'((48 - p) * 42);
    end
endmodule : msrs_motor_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the speed reference selector
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                    mclk, reset, ce, fwd, stepEn, countPulse, rampRestart;
  logic                    behind, drvF, drvR, startPulse, clearPulse;
  msrs_pkg::msrs_sensors_s sensors;
  msrs_pkg::msrs_sum_t     rampLevel, lastRamp, expRamp;
  msrs_pkg::msrs_sel_s     selected;
  msrs_pkg::msrs_sum_t     expQ[$];
  logic [3:0]              cnt;
  logic [2:0]              keep;
  logic [31:0]             lfsr;
  int                      num_errors, n_tests, nClear, nStart, c0;

  msrs_selector dut_u (.mclk(mclk), .reset(reset), .ce(ce), .sensors(sensors),
    .forward_command(fwd), .forward_command_aux(fwd), .countPulse(countPulse),
    .rampRestart(rampRestart), .rampLevel(rampLevel), .selected(selected),
    .motor_behind_flag(behind), .driveForward(drvF), .driveReverse(drvR),
    .startPulse(startPulse), .clearPulse(clearPulse));
  msrs_motor_model model_u (.mclk(mclk), .reset(reset), .stepEn(stepEn),
    .driveForward(drvF), .driveReverse(drvR), .sensors(sensors));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // watcher: pulse counts and every ramp change against the oldest note
  always @(negedge mclk)
  begin
    if (clearPulse === 1'b1) nClear++;
    if (startPulse === 1'b1) nStart++;
    if (!reset && rampLevel !== lastRamp)
    begin
      expRamp = (expQ.size() == 0) ? lastRamp : expQ.pop_front();
      `CHK("rampLevel", expRamp, rampLevel)
      lastRamp = rampLevel;
    end
  end

  task automatic step_clk(input int n);
    repeat (n) @(negedge mclk);
  endtask : step_clk

  task automatic pulse_count;
    countPulse = 1'b1;
    step_clk(2);
    countPulse = 1'b0;
    if (ce)
    begin
      cnt = cnt + 4'h1;
      expQ.push_back(msrs_pkg::RAMP_OFFSET + msrs_pkg::STEP_SIZE * 12'(cnt));
    end
    step_clk(2);
  endtask : pulse_count

  task automatic restart;
    int s0;
    c0 = nClear;
    s0 = nStart;
    rampRestart = 1'b1;
    if (cnt != 4'h0) expQ.push_back(msrs_pkg::RAMP_OFFSET);
    cnt = 4'h0;
    step_clk(2);
    rampRestart = 1'b0;
    step_clk(8);
    `CHK("clearPulse", c0 + 1, nClear)
    `CHK("startPulse", s0 + 3, nStart)
  endtask : restart

  task automatic check_drive;
    `CHK("behind", rampLevel > selected.selLevel, behind)
    `CHK("driveFwd", fwd ? behind : !behind, drvF)
    `CHK("driveRev", !drvF, drvR)
  endtask : check_drive

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #300000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    lfsr = 32'hafa9;
    reset = 1'b1;
    ce = 1'b1;
    fwd = 1'b1;
    stepEn = 1'b0;
    countPulse = 1'b0;
    rampRestart = 1'b0;
    cnt = 4'h0;
    lastRamp = msrs_pkg::RAMP_OFFSET;
    step_clk(12);
    `CHK("resetRamp", msrs_pkg::RAMP_OFFSET, rampLevel)
    `CHK("resetSel", 1'b0, selected.selValid)
    reset = 1'b0;
    step_clk(2);
    for (int d = 0; d < 2; d++)
    begin
      fwd = (d == 0);
      for (int k = 0; k < 4; k++)
      begin
        stepEn = 1'b1;
        lfsr = next_rand(lfsr);
        step_clk(1 + lfsr[3:0]);
        stepEn = 1'b0;
        restart();
        `CHK("selValid", 1'b1, selected.selValid)
        `CHK("belowHalf", 1'b1, selected.selLevel < msrs_pkg::SEL_LIMIT)
        check_drive();
      end
      // frozen clock enable: the count pulse must leave no trace
      ce = 1'b0;
      pulse_count();
      ce = 1'b1;
      c0 = nClear;
      for (int n = 0; n < 17; n++)
      begin
        keep = selected.selIndex;
        lfsr = next_rand(lfsr);
        stepEn = lfsr[0];
        pulse_count();
        stepEn = 1'b0;
        step_clk(4);
        if (n < 15) `CHK("selHold", keep, selected.selIndex)
        check_drive();
      end
      `CHK("wrapStart", c0 + 1, nClear)
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
